// ### bench/pulse_timing_properties.sv
// assertion checker for the clamp and sample pulse timing block
`timescale 1ns/1ps
`include "pulse_timing_consts.svh"

module pulse_timing_properties (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       pixel_clk_in,
    input wire logic       serial_transmit_clock,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       clamp_pulse,
    input wire logic       sample_pulse,
    input wire logic       sample_path_odd,
    input wire logic       monitor_pin_0,
    input wire logic       monitor_pin_1,
    input wire logic       pixel_frame_marker
);
    // ==========================================
    // shadow registers and phase grid model
    logic [7:0] cfg_reg, hold_reg, mon_reg, cs_reg, ce_reg, ss_reg, se_reg;
    logic [5:0] ph_reg;
    logic       pix_prev_reg;
    logic [2:0] quiet_reg;
    wire        hold_m = hold_reg[`BIT_HOLD_ENABLE];
    wire        dbl_m  = !hold_m && cfg_reg[`BIT_CDS_ENABLE];

    function automatic logic win(input logic [5:0] s, input logic [5:0] e, input logic [5:0] p);
        if (s < e) return p >= s && p < e;
        if (s > e) return p >= s || p < e;
        return 1'b0;
    endfunction : win

    always_ff @(posedge core_clk) begin
        if (rst) begin
            {cfg_reg, hold_reg, mon_reg} <= {8'h00, 8'h80, 8'h00};
            {cs_reg, ce_reg, ss_reg, se_reg} <= {8'h00, 8'h10, 8'h20, 8'h3f};
        end else if (reg_wr_en) begin
            case (reg_addr)
                8'h00: cfg_reg <= reg_wdata;
                8'h06: hold_reg <= reg_wdata;
                8'h09: mon_reg <= reg_wdata;
                8'h20: cs_reg <= reg_wdata;
                8'h21: ce_reg <= reg_wdata;
                8'h22: ss_reg <= reg_wdata;
                8'h23: se_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // edge zero trails the clock rise, so a rise reloads the count short of zero
    always_ff @(posedge core_clk) begin
        pix_prev_reg <= pixel_clk_in;
        if (rst)
            ph_reg <= 6'h3f;
        else if (pixel_clk_in && !pix_prev_reg)
            ph_reg <= 6'(`PHASE_EDGES - `EDGE0_TOTAL_LAG);
        else
            ph_reg <= ph_reg + 6'h1;
    end

    // judge placement only once settings have been still for a while
    always_ff @(posedge core_clk) begin
        if (rst || reg_wr_en)
            quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
    end

    // ==========================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    mon_clamp_a: assert property (monitor_pin_0 |-> clamp_pulse)
        else $error("clamp monitor high without clamp pulse");
    mon_sample_a: assert property (monitor_pin_1 |-> sample_pulse)
        else $error("sample monitor high without sample pulse");
    mon_off_a: assert property (quiet_reg == 3'h7 && mon_reg[4:3] != 2'h2
        |-> !monitor_pin_0 && !monitor_pin_1)
        else $error("monitor pins active without pulse selection");
    sample_place_a: assert property (quiet_reg == 3'h7
        |-> sample_pulse == ((hold_m || dbl_m) && win(ss_reg[5:0], se_reg[5:0], $past(ph_reg, 2))))
        else $error("sample pulse off its programmed edges");
    clamp_place_a: assert property (quiet_reg == 3'h7
        |-> clamp_pulse == (dbl_m && win(cs_reg[5:0], ce_reg[5:0], $past(ph_reg, 2))))
        else $error("clamp pulse off its programmed edges");
    hold_path_a: assert property (quiet_reg == 3'h7 && hold_m |-> !sample_path_odd)
        else $error("odd path flagged in hold mode");
    path_toggle_a: assert property (dbl_m && $changed(sample_path_odd) |-> pixel_frame_marker)
        else $error("path flag changed without a pixel marker");
    marker_start_a: assert property ($rose(pixel_frame_marker) |-> $fell(sample_pulse))
        else $error("marker rose without end of sample pulse");

endmodule : pulse_timing_properties

// ### bench/sample_clamp_pulse_timing_test.sv
// self-checking testbench for the clamp and sample pulse timing block
`timescale 1ns/1ps
`include "pulse_timing_consts.svh"
`define CHK(name, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("Error %s expected %0h seen %0h", name, exp, got); \
        end \
    end

module sample_clamp_pulse_timing_test;
    logic       core_clk, rst, run, pixel_clk_in, serial_transmit_clock;
    logic       reg_wr_en, reg_rd_en, clamp_pulse, sample_pulse, sample_path_odd;
    logic       monitor_pin_0, monitor_pin_1, pixel_frame_marker;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    int         comparisons;
    int         miscompares;

    always #2.5 core_clk = ~core_clk;

    sensor_model sensor (.core_clk(core_clk), .run(run), .pixel_clk_in(pixel_clk_in),
        .serial_transmit_clock(serial_transmit_clock));

    sample_clamp_pulse_timing dut (.core_clk(core_clk), .rst(rst),
        .pixel_clk_in(pixel_clk_in), .serial_transmit_clock(serial_transmit_clock),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clamp_pulse(clamp_pulse),
        .sample_pulse(sample_pulse), .sample_path_odd(sample_path_odd),
        .monitor_pin_0(monitor_pin_0), .monitor_pin_1(monitor_pin_1),
        .pixel_frame_marker(pixel_frame_marker));

    // ==========================================
    // shared tasks
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        @(negedge core_clk);
        `CHK("reg_rdata", exp, reg_rdata)
    endtask : rd

    function automatic logic pick(input int s);
        case (s)
            0: return sample_pulse;
            1: return clamp_pulse;
            2: return pixel_frame_marker;
            3: return monitor_pin_1;
            4: return monitor_pin_0;
            default: return pixel_clk_in;
        endcase
    endfunction : pick

    task automatic wait_lvl(input int s, input logic v);
        int i;
        // look only at settled values, never in the launching edge's time step
        @(negedge core_clk);
        for (i = 0; i < 400 && pick(s) !== v; i++) @(negedge core_clk);
        if (i == 400) begin
            miscompares++;
            $display("Error wait_level expected %0h seen %0h", v, pick(s));
            stop_test();
        end
    endtask : wait_lvl

    // a whole pulse only: a pulse already under way is skipped
    task automatic high_len(input int s, output int n);
        wait_lvl(s, 1'b0);
        wait_lvl(s, 1'b1);
        for (n = 0; n < 400 && pick(s) === 1'b1; n++) @(negedge core_clk);
        if (n == 400) begin
            miscompares++;
            $display("Error high_length expected %0d seen %0d", 399, n);
            stop_test();
        end
    endtask : high_len

    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [7:0] ofs [7] = '{8'h00, 8'h06, 8'h09, 8'h20, 8'h21, 8'h22, 8'h23};
        logic [7:0] rv [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h10, 8'h20, 8'h3f};
        foreach (ofs[i]) rd(ofs[i], rv[i]);
        wr(8'h01, 8'hff);
        rd(8'h01, 8'h00);
        wr(8'h20, 8'h15);
        rd(8'h20, 8'h15);
    endtask : t_regs

    task automatic t_edge0();
        int n;
        wr(8'h22, 8'h00);
        wr(8'h23, 8'h20);
        wait_lvl(5, 1'b0);
        wait_lvl(5, 1'b1);
        for (n = 0; n < 99 && sample_pulse !== 1'b1; n++) @(negedge core_clk);
        `CHK("edge0_lag", `EDGE0_TOTAL_LAG + 3, n)
    endtask : t_edge0

    task automatic t_width(input logic [7:0] s, input logic [7:0] e, input int w);
        int h;
        int l;
        wr(8'h22, s);
        wr(8'h23, e);
        high_len(0, h);
        high_len(0, h);
        for (l = 0; l < 99 && sample_pulse === 1'b0; l++) @(negedge core_clk);
        `CHK("sample_width", w, h)
        `CHK("grid_period", 64, h + l)
    endtask : t_width

    task automatic t_hold();
        int n;
        wr(8'h09, 8'h10);
        wr(8'h21, 8'h30);
        high_len(3, n);
        `CHK("monitor_sample", 1, n)
        repeat (2) begin
            high_len(2, n);
            `CHK("marker_hold", 1'b1, n >= 16 && n <= 24)
            `CHK("clamp_hold", 1'b0, clamp_pulse)
        end
    endtask : t_hold

    task automatic t_double();
        int n;
        logic was_short;
        wr(8'h22, 8'h20);
        wr(8'h23, 8'h3f);
        wr(8'h20, 8'h00);
        wr(8'h21, 8'h10);
        wr(8'h06, 8'h00);
        wr(8'h00, 8'h01);
        high_len(2, n);
        high_len(2, n);
        was_short = n <= 8;
        repeat (3) begin
            high_len(2, n);
            `CHK("marker_alternates", !was_short, n <= 8)
            `CHK("marker_odd_len", 1'b1, n <= 8 || (n >= 16 && n <= 24))
            `CHK("path_after_marker", n <= 8, sample_path_odd)
            was_short = n <= 8;
        end
        high_len(1, n);
        `CHK("clamp_width", 16, n)
        high_len(4, n);
        `CHK("monitor_clamp_odd", 16, n)
        wr(8'h20, 8'h20);
        wr(8'h21, 8'h30);
        wr(8'h22, 8'h08);
        wr(8'h23, 8'h18);
        high_len(1, n);
        high_len(1, n);
        for (n = 0; n < 99 && sample_pulse !== 1'b1; n++) @(negedge core_clk);
        `CHK("sample_next_period", 24, n)
        high_len(0, n);
        `CHK("sample_width_double", 16, n)
        wr(8'h00, 8'h00);
        @(negedge core_clk);
        for (n = 0; n < 130 && sample_pulse !== 1'b1; n++) @(negedge core_clk);
        `CHK("idle_no_pulse", 130, n)
    endtask : t_double

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        run = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        comparisons = 0;
        miscompares = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        run <= 1'b1;
        t_regs();
        t_edge0();
        t_width(8'h10, 8'h30, 32);
        t_width(8'h30, 8'h08, 24);
        t_width(8'h3f, 8'h00, 1);
        t_hold();
        t_double();
        stop_test();
    end

endmodule : sample_clamp_pulse_timing_test

bind sample_clamp_pulse_timing pulse_timing_properties chk (.core_clk(core_clk), .rst(rst),
    .pixel_clk_in(pixel_clk_in), .serial_transmit_clock(serial_transmit_clock),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clamp_pulse(clamp_pulse),
    .sample_pulse(sample_pulse), .sample_path_odd(sample_path_odd),
    .monitor_pin_0(monitor_pin_0), .monitor_pin_1(monitor_pin_1),
    .pixel_frame_marker(pixel_frame_marker));

// ### bench/sensor_model.sv
// image sensor side: pixel clock and serial transmit clock source
`timescale 1ns/1ps

module sensor_model #(
    parameter int PIX_CYCLES = 64,
    parameter int TX_HALF    = 4
) (
    input  wire logic core_clk,
    input  wire logic run,
    output logic      pixel_clk_in,
    output logic      serial_transmit_clock
);
    int cnt;

    // both clocks stand low while stopped so no stray edge reaches the block
    initial begin
        cnt = 0;
        pixel_clk_in = 1'b0;
        serial_transmit_clock = 1'b0;
    end

    always @(posedge core_clk) begin
        cnt <= run ? (cnt + 1) % PIX_CYCLES : 0;
        pixel_clk_in <= run && cnt < PIX_CYCLES / 2;
        serial_transmit_clock <= run && (cnt / TX_HALF) % 2 == 1;
    end

endmodule : sensor_model

// ### src/edge_window_pulse.sv
// one pulse placed on the phase grid by a start and an end edge
`timescale 1ns/1ps
`include "pulse_timing_consts.svh"

module edge_window_pulse (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     enable,
    input  wire logic [`PHASE_BITS-1:0]   phase,
    input  wire logic [`PHASE_BITS-1:0]   start_edge,
    input  wire logic [`PHASE_BITS-1:0]   end_edge,
    output logic                          pulse
);

    // ==========================================================
    // window test
    // equal start and end give no pulse at all
    function automatic logic in_window(
        input logic [`PHASE_BITS-1:0] ph,
        input logic [`PHASE_BITS-1:0] st,
        input logic [`PHASE_BITS-1:0] en
    );
        if (st <= en) begin
            in_window = (ph >= st) && (ph < en);
        end else begin
            in_window = (ph >= st) || (ph < en);
        end
    endfunction : in_window

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse <= 1'b0;
        end else begin
            pulse <= enable && in_window(phase, start_edge, end_edge);
        end
    end

endmodule : edge_window_pulse

// ### src/pulse_timing_consts.svh
// constants for the clamp and sample pulse timing block
`ifndef PULSE_TIMING_CONSTS_SVH
`define PULSE_TIMING_CONSTS_SVH

// ==========================================================
// register offsets
`define OFS_MAIN_CONFIGURATION   8'h00
`define OFS_HOLD_MODE_CONTROL    8'h06
`define OFS_CLOCK_MONITOR_SELECT 8'h09
`define OFS_CLAMP_START_EDGE     8'h20
`define OFS_CLAMP_END_EDGE       8'h21
`define OFS_SAMPLE_START_EDGE    8'h22
`define OFS_SAMPLE_END_EDGE      8'h23

// ==========================================================
// field positions
`define BIT_CDS_ENABLE   0
`define BIT_HOLD_ENABLE  7
`define MON_SEL_HI       4
`define MON_SEL_LO       3
`define MON_SEL_PULSES   2'h2

// ==========================================================
// reset values: the baseline configuration, hold mode selected
`define RST_MAIN_CONFIGURATION   8'h00
`define RST_HOLD_MODE_CONTROL    8'h80
`define RST_CLOCK_MONITOR_SELECT 8'h00
`define RST_CLAMP_START_EDGE     8'h00
`define RST_CLAMP_END_EDGE       8'h10
`define RST_SAMPLE_START_EDGE    8'h20
`define RST_SAMPLE_END_EDGE      8'h3f

// ==========================================================
// timing
`define PHASE_EDGES        64
`define PHASE_BITS         6
`define CORE_CLK_PERIOD_PS 5000
`define EDGE0_FIXED_LAG_PS 6000
`define EDGE0_FIXED_LAG_CYC \
    ((`EDGE0_FIXED_LAG_PS + `CORE_CLK_PERIOD_PS - 1) / `CORE_CLK_PERIOD_PS)
`define EDGE0_PERIOD_LAG_EDGES 3
`define EDGE0_TOTAL_LAG (`EDGE0_FIXED_LAG_CYC + `EDGE0_PERIOD_LAG_EDGES)
`define MARKER_ODD_TICKS   3
`define MARKER_EVEN_TICKS  1
`define MARKER_HOLD_TICKS  3

`endif

// ### src/pulse_timing_pkg.sv
// types shared by the clamp and sample pulse timing block
package pulse_timing_pkg;

    typedef enum logic [1:0] {
        MODE_HOLD = 2'b00,
        MODE_CDS  = 2'b01,
        MODE_IDLE = 2'b10
    } sampling_mode_t;

    typedef enum logic [1:0] {
        MK_IDLE = 2'b00,
        MK_HIGH = 2'b01
    } marker_state_t;

endpackage : pulse_timing_pkg

// ### src/sample_clamp_pulse_timing.sv
// clamp and sample pulse timing, monitor routing and even/odd frame marking
`timescale 1ns/1ps
`include "pulse_timing_consts.svh"

module sample_clamp_pulse_timing (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        pixel_clk_in,
    input  wire logic        serial_transmit_clock,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             clamp_pulse,
    output logic             sample_pulse,
    output logic             sample_path_odd,
    output logic             monitor_pin_0,
    output logic             monitor_pin_1,
    output logic             pixel_frame_marker
);

    localparam logic [`PHASE_BITS-1:0] PHASE_LAST     = `PHASE_BITS'(`PHASE_EDGES - 1);
    localparam logic [`PHASE_BITS-1:0] PHASE_AT_RISE  =
        `PHASE_BITS'(`PHASE_EDGES - `EDGE0_TOTAL_LAG);
    localparam logic [1:0]             ODD_TICKS      = 2'(`MARKER_ODD_TICKS);
    localparam logic [1:0]             EVEN_TICKS     = 2'(`MARKER_EVEN_TICKS);
    localparam logic [1:0]             HOLD_TICKS     = 2'(`MARKER_HOLD_TICKS);

    // ==========================================================
    // configuration registers
    // edge registers keep all eight bits for read back; only the low six
    // bits reach the phase grid
    logic [7:0] main_configuration_reg;
    logic [7:0] hold_mode_control_reg;
    logic [7:0] clock_monitor_select_reg;
    logic [7:0] clamp_start_edge_reg;
    logic [7:0] clamp_end_edge_reg;
    logic [7:0] sample_start_edge_reg;
    logic [7:0] sample_end_edge_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            main_configuration_reg   <= `RST_MAIN_CONFIGURATION;
            hold_mode_control_reg    <= `RST_HOLD_MODE_CONTROL;
            clock_monitor_select_reg <= `RST_CLOCK_MONITOR_SELECT;
            clamp_start_edge_reg     <= `RST_CLAMP_START_EDGE;
            clamp_end_edge_reg       <= `RST_CLAMP_END_EDGE;
            sample_start_edge_reg    <= `RST_SAMPLE_START_EDGE;
            sample_end_edge_reg      <= `RST_SAMPLE_END_EDGE;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `OFS_MAIN_CONFIGURATION: begin
                    main_configuration_reg <= reg_wdata;
                end
                `OFS_HOLD_MODE_CONTROL: begin
                    hold_mode_control_reg <= reg_wdata;
                end
                `OFS_CLOCK_MONITOR_SELECT: begin
                    clock_monitor_select_reg <= reg_wdata;
                end
                `OFS_CLAMP_START_EDGE: begin
                    clamp_start_edge_reg <= reg_wdata;
                end
                `OFS_CLAMP_END_EDGE: begin
                    clamp_end_edge_reg <= reg_wdata;
                end
                `OFS_SAMPLE_START_EDGE: begin
                    sample_start_edge_reg <= reg_wdata;
                end
                `OFS_SAMPLE_END_EDGE: begin
                    sample_end_edge_reg <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read data lands one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `OFS_MAIN_CONFIGURATION:   reg_rdata <= main_configuration_reg;
                `OFS_HOLD_MODE_CONTROL:    reg_rdata <= hold_mode_control_reg;
                `OFS_CLOCK_MONITOR_SELECT: reg_rdata <= clock_monitor_select_reg;
                `OFS_CLAMP_START_EDGE:     reg_rdata <= clamp_start_edge_reg;
                `OFS_CLAMP_END_EDGE:       reg_rdata <= clamp_end_edge_reg;
                `OFS_SAMPLE_START_EDGE:    reg_rdata <= sample_start_edge_reg;
                `OFS_SAMPLE_END_EDGE:      reg_rdata <= sample_end_edge_reg;
                default:                   reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // mode decode
    // hold wins when both bits are set, so cds is entered only once
    // hold has been cleared as well
    // with neither bit set both generators stop and no marker is sent
    pulse_timing_pkg::sampling_mode_t mode;

    always_comb begin
        if (hold_mode_control_reg[`BIT_HOLD_ENABLE]) begin
            mode = pulse_timing_pkg::MODE_HOLD;
        end else if (main_configuration_reg[`BIT_CDS_ENABLE]) begin
            mode = pulse_timing_pkg::MODE_CDS;
        end else begin
            mode = pulse_timing_pkg::MODE_IDLE;
        end
    end

    logic hold_active;
    logic cds_active;
    assign hold_active = (mode == pulse_timing_pkg::MODE_HOLD);
    assign cds_active  = (mode == pulse_timing_pkg::MODE_CDS);

    // ==========================================================
    // phase grid
    // the core clock steps one phase edge; a pixel clock rise realigns the
    // counter so that edge zero falls the fixed lag plus three edges later
    // a pixel period other than 64 core cycles makes the grid jump at each
    // realign, so edges near the end of the period are lost or doubled
    logic                    pixel_clk_prev_reg;
    logic [`PHASE_BITS-1:0]  phase_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pixel_clk_prev_reg <= 1'b0;
        end else begin
            pixel_clk_prev_reg <= pixel_clk_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_reg <= PHASE_LAST;
        end else if (pixel_clk_in && !pixel_clk_prev_reg) begin
            phase_reg <= PHASE_AT_RISE;
        end else begin
            phase_reg <= phase_reg + `PHASE_BITS'(1);
        end
    end

    // ==========================================================
    // pulse placement
    // one pair of generators serves both paths, so even and odd pulses
    // sit on the same edges by construction
    logic clamp_raw;
    logic sample_raw;

    edge_window_pulse clamp_gen (
        .core_clk   (core_clk),
        .rst        (rst),
        .enable     (cds_active),
        .phase      (phase_reg),
        .start_edge (clamp_start_edge_reg[`PHASE_BITS-1:0]),
        .end_edge   (clamp_end_edge_reg[`PHASE_BITS-1:0]),
        .pulse      (clamp_raw)
    );

    edge_window_pulse sample_gen (
        .core_clk   (core_clk),
        .rst        (rst),
        .enable     (hold_active || cds_active),
        .phase      (phase_reg),
        .start_edge (sample_start_edge_reg[`PHASE_BITS-1:0]),
        .end_edge   (sample_end_edge_reg[`PHASE_BITS-1:0]),
        .pulse      (sample_raw)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clamp_pulse  <= 1'b0;
            sample_pulse <= 1'b0;
        end else begin
            clamp_pulse  <= clamp_raw;
            sample_pulse <= sample_raw;
        end
    end

    // ==========================================================
    // even/odd path
    // a pixel ends when its sample pulse falls; the sample may sit in the
    // period after its clamp and still belongs to the same pixel
    logic sample_done;
    assign sample_done = sample_pulse && !sample_raw;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sample_path_odd <= 1'b0;
        end else if (!cds_active) begin
            sample_path_odd <= 1'b0;
        end else if (sample_done) begin
            sample_path_odd <= !sample_path_odd;
        end
    end

    // ==========================================================
    // monitor pins
    // in cds only the odd path is shown, so the scope sees every other pixel
    logic show_pulses;
    assign show_pulses =
        (clock_monitor_select_reg[`MON_SEL_HI:`MON_SEL_LO] == `MON_SEL_PULSES);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            monitor_pin_0 <= 1'b0;
            monitor_pin_1 <= 1'b0;
        end else if (show_pulses && (!cds_active || sample_path_odd)) begin
            monitor_pin_0 <= clamp_raw;
            monitor_pin_1 <= sample_raw;
        end else begin
            monitor_pin_0 <= 1'b0;
            monitor_pin_1 <= 1'b0;
        end
    end

    // ==========================================================
    // frame marker
    // counts rising edges of the transmit clock; a new pixel that arrives
    // while a marker runs restarts it, trading the tail for no lost pixel
    pulse_timing_pkg::marker_state_t marker_state_reg;
    logic [1:0]                      marker_left_reg;
    logic                            tx_prev_reg;
    logic                            tx_rise;
    logic [1:0]                      marker_len;

    assign tx_rise = serial_transmit_clock && !tx_prev_reg;

    always_comb begin
        if (!cds_active) begin
            marker_len = HOLD_TICKS;
        end else if (sample_path_odd) begin
            marker_len = ODD_TICKS;
        end else begin
            marker_len = EVEN_TICKS;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_prev_reg <= 1'b0;
        end else begin
            tx_prev_reg <= serial_transmit_clock;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            marker_state_reg   <= pulse_timing_pkg::MK_IDLE;
            marker_left_reg    <= 2'h0;
            pixel_frame_marker <= 1'b0;
        end else if (sample_done) begin
            marker_state_reg   <= pulse_timing_pkg::MK_HIGH;
            marker_left_reg    <= marker_len;
            pixel_frame_marker <= 1'b1;
        end else begin
            case (marker_state_reg)
                pulse_timing_pkg::MK_IDLE: begin
                    pixel_frame_marker <= 1'b0;
                end
                pulse_timing_pkg::MK_HIGH: begin
                    if (tx_rise) begin
                        if (marker_left_reg == 2'h1) begin
                            marker_state_reg   <= pulse_timing_pkg::MK_IDLE;
                            marker_left_reg    <= 2'h0;
                            pixel_frame_marker <= 1'b0;
                        end else begin
                            marker_left_reg <= marker_left_reg - 2'h1;
                        end
                    end
                end
                default: begin
                    marker_state_reg   <= pulse_timing_pkg::MK_IDLE;
                    marker_left_reg    <= 2'h0;
                    pixel_frame_marker <= 1'b0;
                end
            endcase
        end
    end

endmodule : sample_clamp_pulse_timing
